// ### ecd_bridge_sw.sv
// reversing switch pair of the bridge excitation
`timescale 1ns/1ps
module ecd_bridge_sw (
  input wire logic phase,
  input wire logic phase_n,
  output logic fwd,
  output logic rev,
  output logic shoot
);
  // a both-on overlap would short the supply through the bridge
  assign fwd = phase && !phase_n;
  assign rev = phase_n && !phase;
  assign shoot = phase && phase_n;
endmodule

// ### ecd_cfg.svh
// timing counts and reset values for the excitation chop drive
`ifndef ECD_CFG_SVH
`define ECD_CFG_SVH
`define ECD_CLK_MHZ 50
`define ECD_NONOVL_CYCLES 1
`define ECD_PHASE_RST 1'b1
`define ECD_PHASE_N_RST 1'b0
`define ECD_DEFAULT_HALF_PERIOD 16
`endif

// ### ecd_chop_drive.sv
// excitation chop drive: non-overlapping phase outputs and shared port pins
//
// Contract
// RL1: shared negative pin is analog input or digital bit per digital_output_enable.
// RL2: as analog input the pin is the secondary pair's negative terminal.
// RL3: as digital output the pin drives port_bit_zero.
// RL4: companion positive pin as digital output drives port_bit_one.
// RL5: phase output high means normal excitation polarity.
// RL6: phase output low means reversed (chopped) excitation.
// RL7: ac mode off or chop off holds phase output high.
// RL8: second output is complement of phase, toggling in anti-phase.
// RL9: ac mode off or chop off holds complement output low.
// RL10: never both high; both low one master clock at each transition; code skips the gap when toggling stops or srst hits while reversed.
// RL11: chip reset returns all control and configuration to power-on state.
// RL12: both excitation outputs registered on the master clock.
`timescale 1ns/1ps
`include "ecd_cfg.svh"
module ecd_chop_drive #(
  parameter int HALF_W = 16,
  parameter logic [HALF_W-1:0] HALF_PERIOD = HALF_W'(`ECD_DEFAULT_HALF_PERIOD)
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic ac_excitation_mode,
  input wire logic chop_enable,
  input wire logic digital_output_enable,
  input wire logic port_bit_zero,
  input wire logic port_bit_one,
  output logic excitation_phase,
  output logic excitation_phase_n,
  output logic ch2_neg_or_port0_out,
  output logic ch2_neg_or_port0_oe_n,
  output logic ch2_neg_is_analog,
  output logic ch2_pos_or_port1_out,
  output logic ch2_pos_or_port1_oe_n,
  output logic ch2_pos_is_analog
);
  ecd_pkg::ecd_state_e state;
  ecd_pkg::ecd_state_e gap_target;
  logic [HALF_W-1:0] dwell;
  logic toggling;
  localparam logic [HALF_W-1:0] GAP_LAST = HALF_W'(`ECD_NONOVL_CYCLES - 1);

  ecd_port_if port ();

  // configuration bits are plain inputs; the pin module registers them
  assign port.digital_output_enable = digital_output_enable; // [RL1]
  assign port.port_bit_zero = port_bit_zero; // [RL3]
  assign port.port_bit_one = port_bit_one; // [RL4]
  assign ch2_neg_or_port0_out = port.neg_out;
  assign ch2_neg_or_port0_oe_n = port.neg_oe_n;
  assign ch2_neg_is_analog = port.neg_is_analog; // [RL2]
  assign ch2_pos_or_port1_out = port.pos_out;
  assign ch2_pos_or_port1_oe_n = port.pos_oe_n;
  assign ch2_pos_is_analog = port.pos_is_analog;

  ecd_port_pins u_pins (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .port(port)
  );

  // chopping only runs with both ac mode and chop enabled
  assign toggling = ac_excitation_mode & chop_enable; // [RL7] [RL9]

  // phase sequencer: normal -> gap -> reversed -> gap -> normal
  always_ff @(posedge core_clk) begin
    if (srst) begin // [RL11]
      state <= ecd_pkg::ECD_IDLE;
      gap_target <= ecd_pkg::ECD_REVERSED;
      dwell <= '0;
    end else if (clk_en) begin
      if (!toggling) begin
        // leaving ac mode snaps straight back to normal polarity
        state <= ecd_pkg::ECD_IDLE;
        gap_target <= ecd_pkg::ECD_REVERSED;
        dwell <= '0;
      end else begin
        case (state)
          ecd_pkg::ECD_IDLE: begin
            state <= ecd_pkg::ECD_NORMAL;
            dwell <= '0;
          end
          ecd_pkg::ECD_NORMAL: begin
            if (dwell >= HALF_PERIOD - HALF_W'(1)) begin
              state <= ecd_pkg::ECD_GAP; // [RL10]
              gap_target <= ecd_pkg::ECD_REVERSED;
              dwell <= '0;
            end else begin
              dwell <= dwell + HALF_W'(1);
            end
          end
          ecd_pkg::ECD_REVERSED: begin
            if (dwell >= HALF_PERIOD - HALF_W'(1)) begin
              state <= ecd_pkg::ECD_GAP; // [RL10]
              gap_target <= ecd_pkg::ECD_NORMAL;
              dwell <= '0;
            end else begin
              dwell <= dwell + HALF_W'(1);
            end
          end
          ecd_pkg::ECD_GAP: begin
            if (dwell >= GAP_LAST) begin
              state <= gap_target; // one master clock with both low [RL10]
              dwell <= '0;
            end else begin
              dwell <= dwell + HALF_W'(1);
            end
          end
          default: begin
            state <= ecd_pkg::ECD_IDLE;
            dwell <= '0;
          end
        endcase
      end
    end
  end

  // outputs registered so every edge and the gap align to core_clk
  always_ff @(posedge core_clk) begin
    if (srst) begin
      excitation_phase <= `ECD_PHASE_RST; // [RL11]
      excitation_phase_n <= `ECD_PHASE_N_RST;
    end else if (clk_en) begin // [RL12]
      if (!toggling) begin
        excitation_phase <= 1'b1; // [RL7] [RL5]
        excitation_phase_n <= 1'b0; // [RL9]
      end else begin
        case (state)
          ecd_pkg::ECD_IDLE, ecd_pkg::ECD_NORMAL: begin
            excitation_phase <= 1'b1; // [RL5] [RL8]
            excitation_phase_n <= 1'b0;
          end
          ecd_pkg::ECD_REVERSED: begin
            excitation_phase <= 1'b0; // [RL6] [RL8]
            excitation_phase_n <= 1'b1;
          end
          default: begin
            excitation_phase <= 1'b0; // both low in the gap [RL10]
            excitation_phase_n <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// ### ecd_chop_drive_assertions.sv
// port assertions for the excitation chop drive
`timescale 1ns/1ps
module ecd_chop_drive_assertions (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic ac_excitation_mode,
  input wire logic chop_enable,
  input wire logic digital_output_enable,
  input wire logic port_bit_zero,
  input wire logic port_bit_one,
  input wire logic excitation_phase,
  input wire logic excitation_phase_n,
  input wire logic ch2_neg_or_port0_out,
  input wire logic ch2_neg_or_port0_oe_n,
  input wire logic ch2_neg_is_analog,
  input wire logic ch2_pos_or_port1_out,
  input wire logic ch2_pos_or_port1_oe_n,
  input wire logic ch2_pos_is_analog
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // toggling needs both mode bits
  wire tog = ac_excitation_mode && chop_enable;
  a_no_overlap: assert property (!(excitation_phase && excitation_phase_n))
    else $error("both phase outputs high");
  a_idle_level: assert property (clk_en && !tog |=> excitation_phase && !excitation_phase_n)
    else $error("phase not idle");
  a_gap_to_rev: assert property ($fell(excitation_phase) && clk_en && $past(clk_en) && tog
    |=> excitation_phase_n)
    else $error("gap too long");
  a_gap_to_norm: assert property ($fell(excitation_phase_n) && clk_en && $past(clk_en)
    |=> excitation_phase)
    else $error("gap too long");
  a_phase_freeze: assert property (!clk_en && tog |=> $stable(excitation_phase))
    else $error("phase moved while frozen");
  a_port0_dig: assert property (clk_en && digital_output_enable
    |=> ch2_neg_or_port0_out == $past(port_bit_zero) && !ch2_neg_or_port0_oe_n)
    else $error("port bit zero wrong");
  a_port0_ana: assert property (clk_en && !digital_output_enable
    |=> ch2_neg_or_port0_oe_n && ch2_neg_is_analog)
    else $error("shared pin not analog");
  a_port1_dig: assert property (clk_en && digital_output_enable
    |=> ch2_pos_or_port1_out == $past(port_bit_one) && !ch2_pos_or_port1_oe_n)
    else $error("port bit one wrong");
  a_port1_ana: assert property (clk_en && !digital_output_enable
    |=> ch2_pos_or_port1_oe_n && ch2_pos_is_analog && !ch2_pos_or_port1_out)
    else $error("companion pin not analog");
  a_reset_state: assert property (disable iff (1'b0) srst
    |=> excitation_phase && !excitation_phase_n)
    else $error("reset state wrong");
endmodule
bind ecd_chop_drive ecd_chop_drive_assertions ecd_chop_drive_assertions_inst (.*);

// ### ecd_pkg.sv
// types shared by the excitation chop drive modules
package ecd_pkg;
  typedef enum logic [1:0] {
    ECD_IDLE = 2'b00,
    ECD_NORMAL = 2'b01,
    ECD_GAP = 2'b10,
    ECD_REVERSED = 2'b11
  } ecd_state_e;
endpackage

// ### ecd_port_if.sv
// shared digital port pin controls passed from the top to the pin module
`timescale 1ns/1ps
interface ecd_port_if;
  logic digital_output_enable;
  logic port_bit_zero;
  logic port_bit_one;
  logic neg_out;
  logic neg_oe_n;
  logic pos_out;
  logic pos_oe_n;
  logic neg_is_analog;
  logic pos_is_analog;
  modport ctrl (output digital_output_enable, output port_bit_zero, output port_bit_one,
                input neg_out, input neg_oe_n, input pos_out, input pos_oe_n,
                input neg_is_analog, input pos_is_analog);
  modport pins (input digital_output_enable, input port_bit_zero, input port_bit_one,
                output neg_out, output neg_oe_n, output pos_out, output pos_oe_n,
                output neg_is_analog, output pos_is_analog);
endinterface

// ### ecd_port_pins.sv
// registered drivers for the two shared channel-two / digital port pins
`timescale 1ns/1ps
`include "ecd_cfg.svh"
module ecd_port_pins (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  ecd_port_if.pins port
);
  // pins float (analog) after reset until software enables the digital port
  always_ff @(posedge core_clk) begin
    if (srst) begin
      port.neg_out <= 1'b0;
      port.neg_oe_n <= 1'b1;
      port.neg_is_analog <= 1'b1;
      port.pos_out <= 1'b0;
      port.pos_oe_n <= 1'b1;
      port.pos_is_analog <= 1'b1;
    end else if (clk_en) begin
      port.neg_is_analog <= ~port.digital_output_enable; // [RL1] [RL2]
      port.neg_oe_n <= ~port.digital_output_enable; // [RL1]
      port.neg_out <= port.digital_output_enable & port.port_bit_zero; // [RL3]
      port.pos_is_analog <= ~port.digital_output_enable;
      port.pos_oe_n <= ~port.digital_output_enable; // [RL4]
      port.pos_out <= port.digital_output_enable & port.port_bit_one; // [RL4]
    end
  end
endmodule

// ### test_excitation_chop_drive.sv
// self-checking bench for the excitation chop drive
`timescale 1ns/1ps
module test_excitation_chop_drive;
  logic core_clk = 0, srst = 1, clk_en = 1, ac_excitation_mode = 0, chop_enable = 0;
  logic digital_output_enable = 0, port_bit_zero = 0, port_bit_one = 0, fwd, rev, shoot;
  logic excitation_phase, excitation_phase_n, ch2_neg_or_port0_out, ch2_neg_or_port0_oe_n;
  logic ch2_neg_is_analog, ch2_pos_or_port1_out, ch2_pos_or_port1_oe_n, ch2_pos_is_analog;
  logic [5:0] ep = 6'h1B;
  logic [1:0] mo = 2'h2, pr = 2'h2;
  int failures = 0, n_checks = 0, run = 0, rl = 0;
  // reference sequencer: 0 idle, 1 normal, 2 gap, 3 reversed; 16 cycles per polarity
  int ms = 0, mc = 0, mt = 3;
  always #10 core_clk = ~core_clk;
  ecd_chop_drive ecd_chop_drive_inst (.*);
  ecd_bridge_sw ecd_bridge_sw_inst (.phase(excitation_phase), .phase_n(excitation_phase_n),
    .fwd(fwd), .rev(rev), .shoot(shoot));
  task chk(input string nm, input logic [5:0] e, input logic [5:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one cycle: model follows the inputs held since the last falling edge
  task cyc;
    @(negedge core_clk);
    if (srst) begin
      ep = 6'h1B;
      mo = 2'h2;
      ms = 0;
      mc = 0;
      mt = 3;
    end else if (clk_en) begin
      ep[5:3] = digital_output_enable ? {port_bit_zero, 2'h0} : 3'h3;
      ep[2:0] = digital_output_enable ? {port_bit_one, 2'h0} : 3'h3;
      if (!(ac_excitation_mode && chop_enable)) begin
        mo = 2'h2;
        ms = 0;
        mc = 0;
        mt = 3;
      end else begin
        // outputs follow the phase held before this edge
        mo = (ms == 3) ? 2'h1 : (ms == 2) ? 2'h0 : 2'h2;
        if (ms == 0) ms = 1;
        else if (ms == 2) begin
          ms = mt;
          mc = 0;
        end else if (mc >= 15) begin
          mt = (ms == 1) ? 3 : 1;
          ms = 2;
          mc = 0;
        end else mc++;
      end
    end
    chk("ports", ep, {ch2_neg_or_port0_out, ch2_neg_or_port0_oe_n, ch2_neg_is_analog,
      ch2_pos_or_port1_out, ch2_pos_or_port1_oe_n, ch2_pos_is_analog});
    chk("overlap", 6'h00, {5'h00, shoot});
    // run lengths only judged while toggling runs unfrozen
    chk("phase", {4'h0, mo}, {4'h0, excitation_phase, excitation_phase_n});
    chk("switch", {4'h0, mo}, {4'h0, fwd, rev});
    if (rl != 0) begin
      if ({excitation_phase, excitation_phase_n} == pr) run++;
      else begin
        if (pr == 2'h1) chk("rev run", 6'h10, 6'(run));
        if (pr == 2'h0) chk("gap run", 6'h01, 6'(run));
        pr = {excitation_phase, excitation_phase_n};
        run = 1;
      end
    end
  endtask
  task finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    finish_test;
  end
  initial begin
    void'($urandom(32'h886D2F6B));
    repeat (16) cyc;
    srst = 0;
    repeat (200) begin
      cyc;
      {clk_en, ac_excitation_mode, chop_enable, digital_output_enable, port_bit_zero,
        port_bit_one} = 6'($urandom);
    end
    // park in normal first so the run counter starts at a clean polarity
    {clk_en, ac_excitation_mode, chop_enable} = 3'h4;
    cyc;
    {clk_en, ac_excitation_mode, chop_enable} = 3'h7;
    cyc;
    rl = 1;
    repeat (70) cyc;
    rl = 0;
    srst = 1; // reset in mid-toggle
    cyc;
    srst = 0;
    cyc;
    finish_test;
  end
endmodule
